// ### rtl/drdma_top.v
`timescale 1ns/10ps
`default_nettype none
`include "drdma_defs.vh"

module drdma_top #(
  parameter BUF_BYTES = `DRDMA_BUF_BYTES
) (
  input  wire        core_clk,
  input  wire        rst,
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [7:0]  adr_i,
  input  wire [31:0] dat_i,
  input  wire [3:0]  sel_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  output reg         dmaReq,
  output reg         dmaWrite,
  output reg  [31:0] dmaAddr,
  output reg  [31:0] dmaWdata,
  input  wire        dmaAck,
  input  wire [31:0] dmaRdata,
  output reg         txReq,
  output reg  [31:0] txData,
  output reg         txLast,
  input  wire        txAck,
  input  wire        rxReq,
  input  wire [31:0] rxData,
  input  wire        rxLast,
  output reg         rxAck
);
  localparam DEPTH = BUF_BYTES / 4;
  localparam AW    = $clog2(DEPTH);
  localparam [AW:0] RX_THRESH = `DRDMA_RX_THRESH_BYTES / 4;
  localparam [31:0] OWN_MASK  = 32'h00000001 << `DRDMA_DESC_OWN;

  localparam [2:0] TX_IDLE = 3'h0;
  localparam [2:0] TX_CS   = 3'h1;
  localparam [2:0] TX_PTR  = 3'h2;
  localparam [2:0] TX_DATA = 3'h3;
  localparam [2:0] TX_REL  = 3'h4;

  localparam [2:0] RX_IDLE = 3'h0;
  localparam [2:0] RX_CS   = 3'h1;
  localparam [2:0] RX_PTR  = 3'h2;
  localparam [2:0] RX_PAD  = 3'h3;
  localparam [2:0] RX_DATA = 3'h4;
  localparam [2:0] RX_STAT = 3'h5;
  localparam [2:0] RX_DROP = 3'h6;

  localparam [1:0] DR_IDLE = 2'h0;
  localparam [1:0] DR_ACK  = 2'h1;
  localparam [1:0] DR_REL  = 2'h2;

  function [31:0] mergeSel;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  sel;
    integer i;
    begin
      mergeSel = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (sel[i]) begin
          mergeSel[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
    end
  endfunction

  function [7:0] ringNext;
    input [7:0] idx;
    input [7:0] last;
    begin
      ringNext = (idx >= last) ? 8'h00 : idx + 8'h01;
    end
  endfunction

  function [31:0] descAddr;
    input [31:0] base;
    input [7:0]  idx;
    begin
      descAddr = base + {21'h000000, idx, 3'h0};
    end
  endfunction

  reg         txStart_r;
  reg         rxEn_r;
  reg  [31:0] txBase_r;
  reg  [31:0] rxBase_r;
  reg  [3:0]  txSize_r;
  reg  [1:0]  rxSize_r;
  reg  [2:0]  rxPad_r;
  reg  [13:0] rxDrop_r;
  reg  [31:0] rdMux;

  reg  [2:0]  txSt_r;
  reg  [7:0]  txIdx_r;
  reg  [31:0] txCs_r;
  reg  [31:0] txPtr_r;
  reg  [9:0]  txLeft_r;
  reg  [1:0]  drSt_r;

  reg  [2:0]  rxSt_r;
  reg  [7:0]  rxIdx_r;
  reg  [31:0] rxAddr_r;
  reg  [2:0]  rxPadLeft_r;
  reg  [10:0] rxLen_r;
  reg         ldSt_r;
  reg  [AW:0] rxPkts_r;

  reg  [2:0]  rxReqSync_r;
  reg  [2:0]  txAckSync_r;
  reg         rxReqLvl_r;
  reg         txAckLvl_r;

  reg         grantRx_r;
  reg         lastRx_r;
  reg         txBusReq;
  reg         txBusWe;
  reg  [31:0] txBusAddr;
  reg         rxBusReq;
  reg         rxBusWe;
  reg  [31:0] rxBusAddr;
  reg  [31:0] rxBusWdata;

  wire        wbHit = cyc_i & stb_i & ~ack_o;
  wire        wbWr  = wbHit & we_i;
  wire        txDone = dmaReq & dmaAck & ~grantRx_r;
  wire        rxDone = dmaReq & dmaAck & grantRx_r;
  wire        pickRx = rxBusReq & (~txBusReq | ~lastRx_r);
  wire [11:0] txLenW = {1'b0, txCs_r[`DRDMA_DESC_LEN_HI:0]} + 12'h003;

  wire [7:0]  txLastIdx = {txSize_r, 4'hf};
  wire [7:0]  rxLastIdx = (8'h20 << rxSize_r) - 8'h01;

  wire        txFifoWrReady;
  wire        txFifoRdValid;
  wire [32:0] txFifoRdData;
  wire        txFifoWrValid = txDone & (txSt_r == TX_DATA);
  wire        txFifoTag = txCs_r[`DRDMA_DESC_EOP] & (txLeft_r == 10'h001);
  wire        rxFifoWrReady;
  wire        rxFifoRdValid;
  wire [32:0] rxFifoRdData;
  wire [AW:0] rxLevel;
  wire        rxFifoWrValid = ~ldSt_r & rxReqLvl_r;
  wire        rxFifoRdReady = (rxSt_r == RX_DROP) |
                              ((rxSt_r == RX_DATA) & rxDone);
  wire        rxPush = rxFifoWrValid & rxFifoWrReady & rxLast;
  wire        rxPop  = rxFifoRdValid & rxFifoRdReady & rxFifoRdData[32];
  wire        rxReady = (rxPkts_r != {(AW+1){1'b0}}) | (rxLevel >= RX_THRESH);

  drdma_local_buffer #(.AW(AW), .WIDTH(33), .DEPTH(DEPTH)) txBuf (
    .core_clk (core_clk),
    .rst      (rst),
    .wrValid  (txFifoWrValid),
    .wrData   ({txFifoTag, dmaRdata}),
    .wrReady  (txFifoWrReady),
    .rdValid  (txFifoRdValid),
    .rdData   (txFifoRdData),
    .rdReady  (drSt_r == DR_IDLE),
    .level    ()
  );

  drdma_local_buffer #(.AW(AW), .WIDTH(33), .DEPTH(DEPTH)) rxBuf (
    .core_clk (core_clk),
    .rst      (rst),
    .wrValid  (rxFifoWrValid),
    .wrData   ({rxLast, rxData}),
    .wrReady  (rxFifoWrReady),
    .rdValid  (rxFifoRdValid),
    .rdData   (rxFifoRdData),
    .rdReady  (rxFifoRdReady),
    .level    (rxLevel)
  );

  always @* begin
    case ({adr_i[7:2], 2'b00})
      `DRDMA_REG_CTRL:   rdMux = {30'h0, rxEn_r, 1'b0};
      `DRDMA_REG_TXBASE: rdMux = txBase_r;
      `DRDMA_REG_RXBASE: rdMux = rxBase_r;
      `DRDMA_REG_TXSIZE: rdMux = {28'h0, txSize_r};
      `DRDMA_REG_RXSIZE: rdMux = {30'h0, rxSize_r};
      `DRDMA_REG_RXPAD:  rdMux = {29'h0, rxPad_r};
      `DRDMA_REG_STATUS: rdMux = {txSt_r != TX_IDLE, rxSt_r != RX_IDLE,
                                  rxDrop_r, txIdx_r, rxIdx_r};
      default:           rdMux = 32'h00000000;
    endcase
  end

  // register reads use their own data path
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ack_o     <= 1'b0;
      dat_o     <= 32'h00000000;
      txStart_r <= 1'b0;
      rxEn_r    <= 1'b0;
      txBase_r  <= 32'h00000000;
      rxBase_r  <= 32'h00000000;
      txSize_r  <= `DRDMA_RST_TXSIZE;
      rxSize_r  <= `DRDMA_RST_RXSIZE;
      rxPad_r   <= `DRDMA_RST_RXPAD;
    end else begin
      ack_o <= wbHit;
      dat_o <= (wbHit & ~we_i) ? rdMux : 32'h00000000;
      txStart_r <= wbWr & sel_i[0] & dat_i[`DRDMA_CTRL_TXSTART] &
                   ({adr_i[7:2], 2'b00} == `DRDMA_REG_CTRL);
      if (wbWr) begin
        case ({adr_i[7:2], 2'b00})
          `DRDMA_REG_CTRL: begin
            if (sel_i[0]) begin
              rxEn_r <= dat_i[`DRDMA_CTRL_RXEN];
            end
          end
          `DRDMA_REG_TXBASE: txBase_r <= mergeSel(txBase_r, dat_i, sel_i);
          `DRDMA_REG_RXBASE: rxBase_r <= mergeSel(rxBase_r, dat_i, sel_i);
          `DRDMA_REG_TXSIZE: begin
            if (sel_i[0]) begin
              txSize_r <= dat_i[3:0];
            end
          end
          `DRDMA_REG_RXSIZE: begin
            if (sel_i[0]) begin
              rxSize_r <= dat_i[1:0];
            end
          end
          `DRDMA_REG_RXPAD: begin
            if (sel_i[0]) begin
              rxPad_r <= dat_i[2:0];
            end
          end
          default: ;
        endcase
      end
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rxReqSync_r <= 3'h0;
      txAckSync_r <= 3'h0;
      rxReqLvl_r  <= 1'b0;
      txAckLvl_r  <= 1'b0;
    end else begin
      rxReqSync_r <= {rxReqSync_r[1:0], rxReq};
      txAckSync_r <= {txAckSync_r[1:0], txAck};
      if (rxReqSync_r[1] == rxReqSync_r[2]) begin
        rxReqLvl_r <= rxReqSync_r[2];
      end
      if (txAckSync_r[1] == txAckSync_r[2]) begin
        txAckLvl_r <= txAckSync_r[2];
      end
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dmaReq    <= 1'b0;
      dmaWrite  <= 1'b0;
      dmaAddr   <= 32'h00000000;
      dmaWdata  <= 32'h00000000;
      grantRx_r <= 1'b0;
      lastRx_r  <= 1'b0;
    end else if (!dmaReq) begin
      if (txBusReq | rxBusReq) begin
        dmaReq    <= 1'b1;
        grantRx_r <= pickRx;
        lastRx_r  <= pickRx;
        dmaWrite  <= pickRx ? rxBusWe : txBusWe;
        dmaAddr   <= pickRx ? rxBusAddr : txBusAddr;
        dmaWdata  <= pickRx ? rxBusWdata : (txCs_r & ~OWN_MASK);
      end
    end else if (dmaAck) begin
      dmaReq <= 1'b0;
    end
  end

  always @* begin
    txBusReq  = 1'b0;
    txBusWe   = 1'b0;
    txBusAddr = descAddr(txBase_r, txIdx_r);
    case (txSt_r)
      TX_CS:   txBusReq = 1'b1;
      TX_PTR: begin
        txBusReq  = 1'b1;
        txBusAddr = descAddr(txBase_r, txIdx_r) + `DRDMA_DESC_PTR_OFS;
      end
      TX_DATA: begin
        txBusReq  = (txLeft_r != 10'h000) & txFifoWrReady;
        txBusAddr = txPtr_r;
      end
      TX_REL: begin
        txBusReq = 1'b1;
        txBusWe  = 1'b1;
      end
      default: txBusReq = 1'b0;
    endcase
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      txSt_r   <= TX_IDLE;
      txIdx_r  <= 8'h00;
      txCs_r   <= 32'h00000000;
      txPtr_r  <= 32'h00000000;
      txLeft_r <= 10'h000;
    end else begin
      case (txSt_r)
        TX_IDLE: begin
          if (txStart_r) begin
            txSt_r <= TX_CS;
          end
        end
        TX_CS: begin
          if (txDone) begin
            txCs_r <= dmaRdata;
            txSt_r <= dmaRdata[`DRDMA_DESC_OWN] ? TX_PTR : TX_IDLE;
          end
        end
        TX_PTR: begin
          if (txDone) begin
            txPtr_r  <= dmaRdata;
            txLeft_r <= txLenW[11:2];
            txSt_r   <= TX_DATA;
          end
        end
        TX_DATA: begin
          // gather buffers, tag only packet end
          if (txLeft_r == 10'h000) begin
            txSt_r <= TX_REL;
          end else if (txDone) begin
            txPtr_r  <= txPtr_r + 32'h00000004;
            txLeft_r <= txLeft_r - 10'h001;
          end
        end
        TX_REL: begin
          if (txDone) begin
            txIdx_r <= ringNext(txIdx_r, txLastIdx);
            txSt_r  <= TX_CS;
          end
        end
        default: txSt_r <= TX_IDLE;
      endcase
    end
  end

  // Transmit drain handshake toward the MAC
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      drSt_r <= DR_IDLE;
      txReq  <= 1'b0;
      txData <= 32'h00000000;
      txLast <= 1'b0;
    end else begin
      case (drSt_r)
        DR_IDLE: begin
          if (txFifoRdValid) begin
            txData <= txFifoRdData[31:0];
            txLast <= txFifoRdData[32];
            txReq  <= 1'b1;
            drSt_r <= DR_ACK;
          end
        end
        DR_ACK: begin
          if (txAckLvl_r) begin
            txReq  <= 1'b0;
            drSt_r <= DR_REL;
          end
        end
        DR_REL: begin
          if (!txAckLvl_r) begin
            drSt_r <= DR_IDLE;
          end
        end
        default: drSt_r <= DR_IDLE;
      endcase
    end
  end

  // Receive load handshake from the MAC
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ldSt_r   <= 1'b0;
      rxAck    <= 1'b0;
      rxPkts_r <= {(AW+1){1'b0}};
    end else begin
      if (!ldSt_r && rxReqLvl_r && rxFifoWrReady) begin
        rxAck  <= 1'b1;
        ldSt_r <= 1'b1;
      end else if (ldSt_r && !rxReqLvl_r) begin
        rxAck  <= 1'b0;
        ldSt_r <= 1'b0;
      end
      if (rxPush && !rxPop) begin
        rxPkts_r <= rxPkts_r + {{AW{1'b0}}, 1'b1};
      end else if (rxPop && !rxPush) begin
        rxPkts_r <= rxPkts_r - {{AW{1'b0}}, 1'b1};
      end
    end
  end

  always @* begin
    rxBusReq   = 1'b0;
    rxBusWe    = 1'b0;
    rxBusAddr  = descAddr(rxBase_r, rxIdx_r);
    rxBusWdata = {2'b01, 19'h00000, rxLen_r};
    case (rxSt_r)
      RX_CS:   rxBusReq = 1'b1;
      RX_PTR: begin
        rxBusReq  = 1'b1;
        rxBusAddr = descAddr(rxBase_r, rxIdx_r) + `DRDMA_DESC_PTR_OFS;
      end
      RX_PAD: begin
        rxBusReq   = (rxPadLeft_r != 3'h0);
        rxBusWe    = 1'b1;
        rxBusAddr  = rxAddr_r;
        rxBusWdata = 32'h00000000;
      end
      RX_DATA: begin
        rxBusReq   = rxFifoRdValid;
        rxBusWe    = 1'b1;
        rxBusAddr  = rxAddr_r;
        rxBusWdata = rxFifoRdData[31:0];
      end
      RX_STAT: begin
        rxBusReq = 1'b1;
        rxBusWe  = 1'b1;
      end
      default: rxBusReq = 1'b0;
    endcase
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rxSt_r      <= RX_IDLE;
      rxIdx_r     <= 8'h00;
      rxAddr_r    <= 32'h00000000;
      rxPadLeft_r <= 3'h0;
      rxLen_r     <= 11'h000;
      rxDrop_r    <= 14'h0000;
    end else begin
      case (rxSt_r)
        RX_IDLE: begin
          // fetch when a whole packet or the threshold level is buffered
          if (rxEn_r && rxReady) begin
            rxSt_r <= RX_CS;
          end
        end
        RX_CS: begin
          if (rxDone) begin
            if (dmaRdata[`DRDMA_DESC_OWN]) begin
              rxSt_r <= RX_PTR;
            end else begin
              rxSt_r   <= RX_DROP;
              rxDrop_r <= rxDrop_r + 14'h0001;
            end
          end
        end
        RX_PTR: begin
          if (rxDone) begin
            rxAddr_r    <= dmaRdata;
            rxPadLeft_r <= rxPad_r;
            rxLen_r     <= 11'h000;
            rxSt_r      <= RX_PAD;
          end
        end
        RX_PAD: begin
          if (rxPadLeft_r == 3'h0) begin
            rxSt_r <= RX_DATA;
          end else if (rxDone) begin
            rxAddr_r    <= rxAddr_r + 32'h00000004;
            rxPadLeft_r <= rxPadLeft_r - 3'h1;
          end
        end
        RX_DATA: begin
          if (rxDone) begin
            rxAddr_r <= rxAddr_r + 32'h00000004;
            rxLen_r  <= rxLen_r + 11'h004;
            if (rxFifoRdData[32]) begin
              rxSt_r <= RX_STAT;
            end
          end
        end
        RX_STAT: begin
          if (rxDone) begin
            rxIdx_r <= ringNext(rxIdx_r, rxLastIdx);
            rxSt_r  <= RX_IDLE;
          end
        end
        RX_DROP: begin
          if (rxFifoRdValid && rxFifoRdData[32]) begin
            rxSt_r <= RX_IDLE;
          end
        end
        default: rxSt_r <= RX_IDLE;
      endcase
    end
  end
  // single synchronous domain, no frequency-dependent timing
endmodule

`default_nettype wire

// ### rtl/drdma_defs.vh
`ifndef DRDMA_DEFS_VH
`define DRDMA_DEFS_VH

// Register byte offsets
`define DRDMA_REG_CTRL        8'h00
`define DRDMA_REG_TXBASE      8'h04
`define DRDMA_REG_RXBASE      8'h08
`define DRDMA_REG_TXSIZE      8'h0c
`define DRDMA_REG_RXSIZE      8'h10
`define DRDMA_REG_RXPAD       8'h14
`define DRDMA_REG_STATUS      8'h18

// Control bits
`define DRDMA_CTRL_TXSTART    0
`define DRDMA_CTRL_RXEN       1

// Descriptor control/status word
`define DRDMA_DESC_OWN        31
`define DRDMA_DESC_EOP        30
`define DRDMA_DESC_LEN_HI     10
`define DRDMA_DESC_PTR_OFS    32'h00000004

// Status register fields
`define DRDMA_STAT_RXIDX_LO   0
`define DRDMA_STAT_TXIDX_LO   8
`define DRDMA_STAT_DROP_LO    16
`define DRDMA_STAT_RXBUSY     30
`define DRDMA_STAT_TXBUSY     31

// Reset values
`define DRDMA_RST_TXSIZE      4'hf
`define DRDMA_RST_RXSIZE      2'h3
`define DRDMA_RST_RXPAD       3'h0

// Sizes and thresholds
`define DRDMA_BUF_BYTES       2048
`define DRDMA_RX_THRESH_BYTES 128

`endif

// ### rtl/drdma_local_buffer.v
`timescale 1ns/10ps
`default_nettype none

module drdma_local_buffer #(
  parameter AW    = 9,
  parameter WIDTH = 33,
  parameter DEPTH = 512
) (
  input  wire             core_clk,
  input  wire             rst,
  input  wire             wrValid,
  input  wire [WIDTH-1:0] wrData,
  output wire             wrReady,
  output wire             rdValid,
  output wire [WIDTH-1:0] rdData,
  input  wire             rdReady,
  output wire [AW:0]      level
);
  localparam [AW:0] FULL = DEPTH;

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wrPtr_r;
  reg [AW-1:0]    rdPtr_r;
  reg [AW:0]      count_r;

  wire push = wrValid & (count_r != FULL);
  wire pop  = rdReady & (count_r != {(AW+1){1'b0}});

  assign wrReady = (count_r != FULL);
  assign rdValid = (count_r != {(AW+1){1'b0}});
  assign rdData  = mem[rdPtr_r];
  assign level   = count_r;

  // Storage, no reset needed
  always @(posedge core_clk) begin
    if (push) begin
      mem[wrPtr_r] <= wrData;
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wrPtr_r <= {AW{1'b0}};
      rdPtr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wrPtr_r <= wrPtr_r + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rdPtr_r <= rdPtr_r + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push && !pop) begin
        count_r <= count_r + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
        count_r <= count_r - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule

`default_nettype wire

// ### sim/drdma_top_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module drdma_checker (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        dmaReq,
  input wire logic        dmaWrite,
  input wire logic [31:0] dmaAddr,
  input wire logic [31:0] dmaWdata,
  input wire logic        dmaAck,
  input wire logic        txReq,
  input wire logic [31:0] txData,
  input wire logic        txLast,
  input wire logic        txAck,
  input wire logic        rxReq,
  input wire logic        rxAck
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence wbTake;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence txSeen;
    txReq [*2] ##[1:8] !txReq;
  endsequence
  a_ack_next: assert property (wbTake |=> ack_o)
    else $error("bus access not answered next cycle");
  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("bus answer longer than one cycle");
  a_write_zero: assert property (ack_o && $past(we_i) |-> dat_o == 32'h0)
    else $error("read data not zero on write");
  a_dma_hold: assert property (dmaReq && !dmaAck |=> dmaReq &&
    $stable(dmaAddr) && $stable(dmaWrite) && $stable(dmaWdata))
    else $error("dma request changed before answer");
  a_dma_drop: assert property (dmaReq && dmaAck |=> !dmaReq)
    else $error("dma request held after answer");
  a_tx_hold: assert property (txReq && !txAck |=>
    txReq && $stable(txData) && $stable(txLast))
    else $error("transmit word changed before acknowledge");
  a_tx_release: assert property ($rose(txAck) |-> txSeen)
    else $error("transmit request release out of window");
  a_rx_sync: assert property ($rose(rxReq) |-> !rxAck [*2])
    else $error("receive acknowledge without synchronising");
  a_rx_release: assert property ($fell(rxReq) |-> ##[1:8] !rxAck)
    else $error("receive acknowledge not released");
endmodule
bind drdma_top drdma_checker u_drdma_checker (
  .core_clk(core_clk), .rst(rst), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .dat_o(dat_o), .ack_o(ack_o), .dmaReq(dmaReq),
  .dmaWrite(dmaWrite), .dmaAddr(dmaAddr), .dmaWdata(dmaWdata),
  .dmaAck(dmaAck), .txReq(txReq), .txData(txData), .txLast(txLast),
  .txAck(txAck), .rxReq(rxReq), .rxAck(rxAck)
);
`default_nettype wire

// ### sim/drdma_host_mem.sv
`timescale 1ns/10ps
`default_nettype none
module drdma_host_mem (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [2:0]  delay,
  input  wire logic        dmaReq,
  input  wire logic        dmaWrite,
  input  wire logic [31:0] dmaAddr,
  input  wire logic [31:0] dmaWdata,
  output var  logic        dmaAck,
  output var  logic [31:0] dmaRdata
);
  logic [31:0] mem [0:511];
  logic [2:0]  waitCnt_r;
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dmaAck    <= 1'b0;
      dmaRdata  <= 32'h0;
      waitCnt_r <= 3'h0;
    end else begin
      dmaAck   <= 1'b0;
      dmaRdata <= ~dmaRdata;
      if (dmaReq && !dmaAck) begin
        if (waitCnt_r == delay) begin
          dmaAck    <= 1'b1;
          waitCnt_r <= 3'h0;
          if (dmaWrite)
            mem[dmaAddr[10:2]] <= dmaWdata;
          else
            dmaRdata <= mem[dmaAddr[10:2]];
        end else begin
          waitCnt_r <= waitCnt_r + 3'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### sim/descriptor_ring_dma_bench.sv
`timescale 1ns/10ps
`default_nettype none
module descriptor_ring_dma_bench;
  logic        core_clk, rst, cyc, stb, we, txAck, rxReq, rxLast;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [2:0]  memDelay;
  logic [31:0] wdat, rxData, seed;
  wire  [31:0] datO, dmaAddr, dmaWdata, dmaRdata, txData;
  wire         ackO, dmaReq, dmaWrite, dmaAck, txReq, txLast, rxAck;
  logic [32:0] rdQ[$], txQ[$];
  integer      failures, comparisons, cycles;
  drdma_top u_drdma_top (
    .core_clk(core_clk), .rst(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .dat_i(wdat), .sel_i(sel), .dat_o(datO), .ack_o(ackO),
    .dmaReq(dmaReq), .dmaWrite(dmaWrite), .dmaAddr(dmaAddr),
    .dmaWdata(dmaWdata), .dmaAck(dmaAck), .dmaRdata(dmaRdata),
    .txReq(txReq), .txData(txData), .txLast(txLast), .txAck(txAck),
    .rxReq(rxReq), .rxData(rxData), .rxLast(rxLast), .rxAck(rxAck)
  );
  drdma_host_mem u_drdma_host_mem (
    .core_clk(core_clk), .rst(rst), .delay(memDelay), .dmaReq(dmaReq),
    .dmaWrite(dmaWrite), .dmaAddr(dmaAddr), .dmaWdata(dmaWdata),
    .dmaAck(dmaAck), .dmaRdata(dmaRdata)
  );
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [32:0] g, input logic [32:0] e);
    comparisons = comparisons + 1;
    if (g !== e) begin
      failures = failures + 1;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic results;
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    if (!w)
      rdQ.push_back({1'b0, d});
    @(posedge core_clk);
    while (ackO !== 1'b1)
      @(posedge core_clk);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rxw(input logic [31:0] d, input logic l);
    @(posedge core_clk);
    rxReq  <= 1'b1;
    rxData <= d;
    rxLast <= l;
    while (rxAck !== 1'b1)
      @(posedge core_clk);
    rxReq  <= 1'b0;
    rxData <= ~d;
    rxLast <= ~l;
    while (rxAck !== 1'b0)
      @(posedge core_clk);
  endtask
  task automatic quiet;
    integer n;
    n = 0;
    while (n < 16) begin
      @(posedge core_clk);
      n = dmaReq ? 0 : n + 1;
    end
  endtask
  // Read answers and transmit words
  always @(posedge core_clk) begin
    if (ackO === 1'b1 && we === 1'b0)
      chk({1'b0, datO}, rdQ.pop_front());
    if (txReq === 1'b1 && txAck === 1'b0) begin
      chk({txLast, txData}, txQ.pop_front());
      txAck <= 1'b1;
    end else if (txReq === 1'b0) begin
      txAck <= 1'b0;
    end
    cycles = cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      results();
    end
  end
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  initial begin : main
    integer i, j;
    logic [31:0] d0, d1;
    {cyc, stb, we, txAck, rxReq, rxLast} = 6'h0;
    {adr, wdat, rxData, memDelay} = 75'h0;
    sel = 4'hf;
    seed = 32'd95525;
    {failures, comparisons, cycles} = 96'h0;
    for (i = 0; i < 512; i = i + 1)
      u_drdma_host_mem.mem[i] = 32'h0;
    rst = 1'b1;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    for (i = 0; i < 32; i = i + 4) begin
      d0 = (i == 12) ? 32'hf : (i == 16) ? 32'h3 : 32'h0;
      wb(1'b0, i[7:0], d0);
    end
    d0 = lfsr(seed);
    d1 = lfsr(d0);
    u_drdma_host_mem.mem[0] = 32'h80000004;
    u_drdma_host_mem.mem[1] = 32'h00000100;
    u_drdma_host_mem.mem[2] = 32'hc0000004;
    u_drdma_host_mem.mem[3] = 32'h00000104;
    u_drdma_host_mem.mem[64] = d0;
    u_drdma_host_mem.mem[65] = d1;
    txQ.push_back({1'b0, d0});
    txQ.push_back({1'b1, d1});
    wb(1'b1, 8'h0c, 32'h0);
    wb(1'b1, 8'h00, 32'h1);
    quiet();
    chk({1'b0, u_drdma_host_mem.mem[0]}, 33'h000000004);
    chk({1'b0, u_drdma_host_mem.mem[2]}, 33'h040000004);
    chk(txQ.size(), 33'h0);
    wb(1'b0, 8'h18, 32'h00000200);
    seed = lfsr(d1);
    memDelay <= seed[2:0];
    d0 = lfsr(seed);
    d1 = lfsr(d0);
    u_drdma_host_mem.mem[128] = 32'h80000000;
    u_drdma_host_mem.mem[129] = 32'h00000300;
    wb(1'b1, 8'h08, 32'h200);
    wb(1'b1, 8'h10, 32'h0);
    wb(1'b1, 8'h14, 32'h1);
    wb(1'b1, 8'h00, 32'h2);
    rxw(d0, 1'b0);
    rxw(d1, 1'b1);
    quiet();
    chk({1'b0, u_drdma_host_mem.mem[193]}, {1'b0, d0});
    chk({1'b0, u_drdma_host_mem.mem[194]}, {1'b0, d1});
    chk({1'b0, u_drdma_host_mem.mem[128]}, 33'h040000008);
    wb(1'b0, 8'h18, 32'h00000201);
    rxw(lfsr(d1), 1'b1);
    quiet();
    wb(1'b0, 8'h18, 32'h00010201);
    u_drdma_host_mem.mem[130] = 32'h80000000;
    u_drdma_host_mem.mem[131] = 32'h00000380;
    rxw(d0 ^ d1, 1'b1);
    quiet();
    chk({1'b0, u_drdma_host_mem.mem[225]}, {1'b0, d0 ^ d1});
    chk({1'b0, u_drdma_host_mem.mem[130]}, 33'h040000004);
    wb(1'b0, 8'h18, 32'h00010202);
    // Owned transmit ring 2..15 then 0; idle until the next start
    for (i = 0; i < 15; i = i + 1) begin
      j = (i + 2) % 16;
      seed = lfsr(seed);
      u_drdma_host_mem.mem[2 * j] = 32'hc0000004;
      u_drdma_host_mem.mem[2 * j + 1] = 32'd1200 + 4 * i;
      u_drdma_host_mem.mem[300 + i] = seed;
      txQ.push_back({1'b1, seed});
    end
    // Long receive packet starts on the word threshold
    u_drdma_host_mem.mem[132] = 32'h80000000;
    u_drdma_host_mem.mem[133] = 32'h00000400;
    d0 = lfsr(seed);
    d1 = lfsr(d0);
    for (i = 0; i < 32; i = i + 1) begin
      rxw(d0 + i, 1'b0);
    end
    wb(1'b0, 8'h18, 32'h40010202);
    rxw(d1, 1'b1);
    quiet();
    chk({1'b0, u_drdma_host_mem.mem[257]}, {1'b0, d0});
    chk({1'b0, u_drdma_host_mem.mem[288]}, {1'b0, d0 + 32'd31});
    chk({1'b0, u_drdma_host_mem.mem[289]}, {1'b0, d1});
    chk({1'b0, u_drdma_host_mem.mem[132]}, 33'h040000084);
    wb(1'b1, 8'h00, 32'h3);
    quiet();
    repeat (64) @(posedge core_clk);
    chk(txQ.size(), 33'h0);
    chk({1'b0, u_drdma_host_mem.mem[0]}, 33'h040000004);
    wb(1'b0, 8'h18, 32'h00010103);
    results();
  end
endmodule
`default_nettype wire
